// *** core/sac_ctrl.sv ***
// Operation
// - No input connected unless gate is set
// - Channel code picks pad or quarter supply
// - Pin config bits map to A0-7, B0-2
// - Config bit 1 makes pad analog only
// - Bit decisions step on conversion clock
// - Divider codes give /16, /8, /1, /2
// - Sample window 1, 2, 4, 8 periods
// - Resolution codes 8, 10, 12 bits
// - Time is window plus bits plus two
// - Writing start begins one conversion
// - Done reads 0 during conversion
// - Done sets at end, interrupt available
// - Interrupt flag stays until written 0
// - Flag reads set only when enabled
// - Request needs both interrupt enables
//
// Register access over APB and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "sac_defs.svh"

module sac_ctrl (
  input  wire logic        i_clock,
  input  wire logic        i_rst,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  input  wire logic        i_comp,
  output logic [31:0]      o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  output logic [11:0]      o_chan_onehot,
  output logic             o_quarter_sel,
  output logic [11:0]      o_pad_analog,
  output logic             o_sample,
  output logic             o_bit_step,
  output logic [11:0]      o_dac_code,
  output logic             o_irq
);

  logic [15:0]          ctrl_q;
  logic [7:0]           pina_q;
  logic [4:0]           chan_q;
  logic                 done_q;
  logic                 irqf_q;
  logic [11:0]          result_q;
  logic [11:0]          sar_q;
  logic [3:0]           bit_q;
  logic [3:0]           shcnt_q;
  sac_pkg::sac_state_t  state_q;
  sac_pkg::sac_cfg_t    cfg;
  logic                 tick;
  logic                 wr;
  logic                 rd_en;
  logic                 start_req;
  logic                 eoc;
  logic [3:0]           nbits;
  logic [3:0]           shlast;
  logic [11:0]          trial;

  // -----------------------------------------------------------------
  // Decoding helpers
  // -----------------------------------------------------------------
  function automatic logic [3:0] bits_of(input logic [1:0] res);
    if (res[1]) begin
      bits_of = 4'hc;
    end else if (res[0]) begin
      bits_of = 4'ha;
    end else begin
      bits_of = 4'h8;
    end
  endfunction

  function automatic logic [3:0] win_last(input logic [1:0] shw);
    unique case (shw)
      2'b00: win_last = 4'h0;
      2'b01: win_last = 4'h1;
      2'b10: win_last = 4'h3;
      2'b11: win_last = 4'h7;
    endcase
  endfunction

  always_comb begin
    cfg.res  = ctrl_q[`SAC_CTRL_RES_HI:`SAC_CTRL_RES_LO];
    cfg.div  = ctrl_q[`SAC_CTRL_DIV_HI:`SAC_CTRL_DIV_LO];
    cfg.shw  = ctrl_q[`SAC_CTRL_SHW_HI:`SAC_CTRL_SHW_LO];
    cfg.en   = ctrl_q[`SAC_CTRL_EN];
    cfg.chan = chan_q[`SAC_CHAN_SEL_HI:`SAC_CHAN_SEL_LO];
    cfg.gate = chan_q[`SAC_CHAN_GATE];
  end

  assign nbits  = bits_of(cfg.res);
  assign shlast = win_last(cfg.shw);

  // -----------------------------------------------------------------
  // APB slave
  // -----------------------------------------------------------------
  // Answers in the first access cycle; outputs are registered off the
  // setup phase, so no wait state is needed.
  assign wr    = i_psel && i_penable && i_pwrite && o_pready;
  assign rd_en = i_psel && !i_penable && !i_pwrite;

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_pready <= 1'b0;
    end else begin
      o_pready <= i_psel && !i_penable;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_pslverr <= 1'b0;
    end else if (i_psel && !i_penable) begin
      o_pslverr <= !(i_paddr inside {`SAC_OFF_CTRL, `SAC_OFF_CHAN,
                     `SAC_OFF_PINCFG, `SAC_OFF_STATUS, `SAC_OFF_RESULT});
    end else begin
      o_pslverr <= 1'b0;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_prdata <= 32'h0000_0000;
    end else if (rd_en) begin
      unique case (i_paddr)
        `SAC_OFF_CTRL:   o_prdata <= {16'h0000, ctrl_q};
        `SAC_OFF_CHAN:   o_prdata <= {27'h0000000, chan_q};
        `SAC_OFF_PINCFG: o_prdata <= {24'h000000, pina_q};
        `SAC_OFF_STATUS: o_prdata <= {29'h00000000,
                                      state_q != sac_pkg::SAC_IDLE,
                                      irqf_q && ctrl_q[`SAC_CTRL_IE],
                                      done_q};
        `SAC_OFF_RESULT: o_prdata <= {20'h00000, result_q};
        default:         o_prdata <= 32'h0000_0000;
      endcase
    end else begin
      o_prdata <= 32'h0000_0000;
    end
  end

  // -----------------------------------------------------------------
  // Configuration registers
  // -----------------------------------------------------------------
  // Start is ignored while disabled and clears when the run begins
  assign start_req = ctrl_q[`SAC_CTRL_START] && cfg.en;

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      ctrl_q <= `SAC_CTRL_RST;
    end else if (wr && i_paddr == `SAC_OFF_CTRL) begin
      ctrl_q <= i_pwdata[15:0];
      ctrl_q[`SAC_CTRL_START] <= i_pwdata[`SAC_CTRL_START]
                                 && i_pwdata[`SAC_CTRL_EN];
    end else if (start_req && state_q == sac_pkg::SAC_IDLE) begin
      ctrl_q[`SAC_CTRL_START] <= 1'b0;
    end else if (!cfg.en) begin
      ctrl_q[`SAC_CTRL_START] <= 1'b0;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      chan_q <= 5'h00;
    end else if (wr && i_paddr == `SAC_OFF_CHAN) begin
      chan_q <= i_pwdata[4:0];
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      pina_q <= `SAC_PINA_RST;
    end else if (wr && i_paddr == `SAC_OFF_PINCFG) begin
      pina_q <= i_pwdata[7:0];
    end
  end

  // -----------------------------------------------------------------
  // Pad and channel routing
  // -----------------------------------------------------------------
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_pad_analog <= 12'h000;
    end else begin
      o_pad_analog <= {1'b0,
                       ctrl_q[`SAC_CTRL_PINB_HI:`SAC_CTRL_PINB_LO],
                       pina_q};
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_chan_onehot <= 12'h000;
      o_quarter_sel <= 1'b0;
    end else if (!cfg.gate) begin
      o_chan_onehot <= 12'h000;
      o_quarter_sel <= 1'b0;
    end else begin
      o_quarter_sel <= cfg.chan == 4'hb;
      o_chan_onehot <= (cfg.chan <= 4'ha) ? 12'h001 << cfg.chan
                                          : 12'h000;
    end
  end

  // -----------------------------------------------------------------
  // Conversion sequencer
  // -----------------------------------------------------------------
  sac_clkdiv u_div (
    .i_clock (i_clock),
    .i_rst   (i_rst),
    .i_run   (state_q != sac_pkg::SAC_IDLE),
    .i_div   (cfg.div),
    .o_tick  (tick)
  );

  // Window, then one period per bit, then two settling periods
  assign eoc = state_q == sac_pkg::SAC_FINISH && tick
               && bit_q == 4'h1;

  always_ff @(posedge i_clock) begin
    if (i_rst || !cfg.en) begin
      state_q <= sac_pkg::SAC_IDLE;
      shcnt_q <= 4'h0;
      bit_q   <= 4'h0;
      sar_q   <= 12'h000;
    end else begin
      unique case (state_q)
        sac_pkg::SAC_IDLE: begin
          if (start_req) begin
            state_q <= sac_pkg::SAC_SAMPLE;
            shcnt_q <= 4'h0;
            sar_q   <= 12'h000;
          end
        end
        sac_pkg::SAC_SAMPLE: begin
          if (tick) begin
            if (shcnt_q == shlast) begin
              state_q <= sac_pkg::SAC_CONV;
              bit_q   <= nbits;
            end else begin
              shcnt_q <= shcnt_q + 4'h1;
            end
          end
        end
        sac_pkg::SAC_CONV: begin
          if (tick) begin
            sar_q[4'hb - (nbits - bit_q)] <= i_comp;
            if (bit_q == 4'h1) begin
              state_q <= sac_pkg::SAC_FINISH;
              bit_q   <= `SAC_EXTRA_CLKS;
            end else begin
              bit_q <= bit_q - 4'h1;
            end
          end
        end
        sac_pkg::SAC_FINISH: begin
          if (tick) begin
            if (bit_q == 4'h1) begin
              state_q <= sac_pkg::SAC_IDLE;
            end else begin
              bit_q <= bit_q - 4'h1;
            end
          end
        end
      endcase
    end
  end

  // Trial code: decided bits plus the bit under test. It is built one
  // decision ahead so that an undivided clock still sees a settled code.
  assign trial = 12'h800 >> (nbits - bit_q);

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_dac_code <= 12'h000;
    end else if (state_q == sac_pkg::SAC_SAMPLE) begin
      o_dac_code <= 12'h800;
    end else if (state_q == sac_pkg::SAC_CONV) begin
      if (tick) begin
        o_dac_code <= sar_q | (i_comp ? trial : 12'h000)
                      | ((bit_q == 4'h1) ? 12'h000 : trial >> 1);
      end
    end else begin
      o_dac_code <= sar_q;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_sample   <= 1'b0;
      o_bit_step <= 1'b0;
    end else begin
      o_sample   <= state_q == sac_pkg::SAC_SAMPLE;
      o_bit_step <= state_q == sac_pkg::SAC_CONV && tick;
    end
  end

  // -----------------------------------------------------------------
  // Done, result and interrupt flag
  // -----------------------------------------------------------------
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      done_q <= 1'b0;
    end else if (eoc) begin
      done_q <= 1'b1;
    end else if (start_req && state_q == sac_pkg::SAC_IDLE) begin
      done_q <= 1'b0;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      result_q <= 12'h000;
    end else if (eoc) begin
      result_q <= sar_q;
    end
  end

  // Event wins over a software clear in the same cycle
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      irqf_q <= 1'b0;
    end else if (eoc) begin
      irqf_q <= 1'b1;
    end else if (wr && i_paddr == `SAC_OFF_STATUS
                 && !i_pwdata[`SAC_STAT_IRQF]) begin
      irqf_q <= 1'b0;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= irqf_q && ctrl_q[`SAC_CTRL_IE]
               && ctrl_q[`SAC_CTRL_GIE];
    end
  end

endmodule

`default_nettype wire

// *** core/sac_defs.svh ***
`ifndef SAC_DEFS_SVH
`define SAC_DEFS_SVH

// -----------------------------------------------------------------
// Register byte offsets
// -----------------------------------------------------------------
`define SAC_OFF_CTRL     12'h000
`define SAC_OFF_CHAN     12'h004
`define SAC_OFF_PINCFG   12'h008
`define SAC_OFF_STATUS   12'h00c
`define SAC_OFF_RESULT   12'h010

// -----------------------------------------------------------------
// Control register fields
// -----------------------------------------------------------------
`define SAC_CTRL_RES_LO  0
`define SAC_CTRL_RES_HI  1
`define SAC_CTRL_PINB_LO 4
`define SAC_CTRL_PINB_HI 6
`define SAC_CTRL_DIV_LO  8
`define SAC_CTRL_DIV_HI  9
`define SAC_CTRL_SHW_LO  10
`define SAC_CTRL_SHW_HI  11
`define SAC_CTRL_EN      12
`define SAC_CTRL_START   13
`define SAC_CTRL_IE      14
`define SAC_CTRL_GIE     15

// Channel register fields
`define SAC_CHAN_SEL_LO  0
`define SAC_CHAN_SEL_HI  3
`define SAC_CHAN_GATE    4

// Status register fields
`define SAC_STAT_DONE    0
`define SAC_STAT_IRQF    1
`define SAC_STAT_BUSY    2

// -----------------------------------------------------------------
// Reset values and counts
// -----------------------------------------------------------------
`define SAC_CTRL_RST     16'h0000
`define SAC_PINA_RST     8'h00
`define SAC_EXTRA_CLKS   4'h2
`define SAC_CLK_MHZ      25
`define SAC_BIAS_US      256
`define SAC_BIAS_CYC     (`SAC_BIAS_US * `SAC_CLK_MHZ)

`endif

// *** core/sac_pkg.sv ***
package sac_pkg;

  typedef struct packed {
    logic [1:0] res;
    logic [1:0] div;
    logic [1:0] shw;
    logic       en;
    logic [3:0] chan;
    logic       gate;
  } sac_cfg_t;

  typedef struct packed {
    logic        sample;
    logic        step;
    logic        latch;
    logic [11:0] pads;
  } sac_ana_t;

  typedef enum logic [3:0] {
    SAC_IDLE   = 4'b0001,
    SAC_SAMPLE = 4'b0010,
    SAC_CONV   = 4'b0100,
    SAC_FINISH = 4'b1000
  } sac_state_t;

endpackage

// *** core/sac_clkdiv.sv ***
`timescale 1ns/1ps
`default_nettype none

module sac_clkdiv (
  input  wire logic       i_clock,
  input  wire logic       i_rst,
  input  wire logic       i_run,
  input  wire logic [1:0] i_div,
  output logic            o_tick
);

  logic [3:0] cnt_q;
  logic [3:0] last;

  // -----------------------------------------------------------------
  // Divider ratio
  // -----------------------------------------------------------------
  always_comb begin
    unique case (i_div)
      2'b00: last = 4'hf;
      2'b01: last = 4'h7;
      2'b10: last = 4'h0;
      2'b11: last = 4'h1;
    endcase
  end

  // Restarts with each conversion so the first period is a full one
  always_ff @(posedge i_clock) begin
    if (i_rst || !i_run || cnt_q >= last) begin
      cnt_q <= 4'h0;
    end else begin
      cnt_q <= cnt_q + 4'h1;
    end
  end

  assign o_tick = i_run && (cnt_q >= last);

endmodule

`default_nettype wire

// *** dv/sac_ctrl_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
module sac_ctrl_asserts (
  input wire logic        i_clock,
  input wire logic        i_rst,
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic        i_comp,
  input wire logic [31:0] o_prdata,
  input wire logic        o_pready,
  input wire logic        o_pslverr,
  input wire logic [11:0] o_chan_onehot,
  input wire logic        o_quarter_sel,
  input wire logic [11:0] o_pad_analog,
  input wire logic        o_sample,
  input wire logic        o_bit_step,
  input wire logic [11:0] o_dac_code,
  input wire logic        o_irq
);
  // ------
  // Shadow of the written enables
  // ------
  logic wr_c;
  logic ie_q;
  logic gie_q;
  logic en_q;
  logic gate_q;
  assign wr_c = i_psel && i_penable && i_pwrite && o_pready;
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      ie_q <= 1'b0;
      gie_q <= 1'b0;
      en_q <= 1'b0;
    end else if (wr_c && i_paddr == 12'h000) begin
      ie_q <= i_pwdata[14];
      gie_q <= i_pwdata[15];
      en_q <= i_pwdata[12];
    end
  end
  always_ff @(posedge i_clock) begin
    if (i_rst) gate_q <= 1'b0;
    else if (wr_c && i_paddr == 12'h004) gate_q <= i_pwdata[4];
  end
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);
  // Pads may lag the write by one stage, so look two edges on
  AST_READY: assert property (i_psel && !i_penable |=> o_pready)
    else $error("no answer in first access cycle");
  AST_ERR: assert property (o_pslverr |-> o_pready && o_prdata == 32'h0)
    else $error("error without ready or with data");
  AST_UNMAP: assert property (i_psel && !i_penable && i_paddr > 12'h010
    |=> o_pslverr) else $error("unmapped access not refused");
  AST_GATE: assert property (!gate_q [*2] |->
    o_chan_onehot == 12'h000 && !o_quarter_sel) else $error("gate off");
  AST_ONEHOT: assert property ($onehot0({o_chan_onehot, o_quarter_sel}))
    else $error("two inputs selected");
  AST_PADB: assert property (wr_c && i_paddr == 12'h000 |-> ##2
    o_pad_analog[10:8] == $past(i_pwdata[6:4], 2)) else $error("pad b");
  AST_PADA: assert property (wr_c && i_paddr == 12'h008 |-> ##2
    o_pad_analog[7:0] == $past(i_pwdata[7:0], 2)) else $error("pad a");
  AST_IRQ: assert property (!(ie_q && gie_q) [*2] |-> !o_irq)
    else $error("request while masked");
  AST_IDLE: assert property (!en_q [*3] |-> !o_sample && !o_bit_step)
    else $error("activity while disabled");
  cover property (o_bit_step);
  cover property (o_irq);
  cover property (o_quarter_sel);
endmodule
`default_nettype wire

// *** dv/sac_ana_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module sac_ana_model (
  input wire logic [11:0] i_dac_code,
  input wire logic [11:0] i_chan_onehot,
  input wire logic        i_quarter_sel,
  input wire logic [11:0] i_level,
  output logic            o_comp
);
  // ------
  // Comparator of the analog core
  // ------
  // A floating input follows the trial code, never a stale level
  always_comb begin
    // Selected pad is an input with pulls off, so its level is undisturbed
    if (|i_chan_onehot || i_quarter_sel) o_comp = i_level >= i_dac_code;
    else o_comp = ~i_dac_code[11];
  end
endmodule
`default_nettype wire

// *** dv/sac_ctrl_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module sac_ctrl_test;
  // ------
  // Bench
  // ------
  logic        i_clock = 1'b0;
  logic        i_rst = 1'b1;
  logic        i_psel = 1'b0;
  logic        i_penable = 1'b0;
  logic        i_pwrite = 1'b0;
  logic [11:0] i_paddr = 12'h000;
  logic [31:0] i_pwdata = 32'h0;
  logic        i_comp;
  logic [31:0] o_prdata;
  logic        o_pready, o_pslverr, o_quarter_sel, o_sample, o_bit_step;
  logic        o_irq;
  logic [11:0] o_chan_onehot, o_pad_analog, o_dac_code;
  logic [11:0] level = 12'ha5c;
  logic [31:0] rd;
  logic        err;
  int          n_fail = 0;
  int          total_checks = 0;
  int          cyc = 0;
  int          n_step = 0;
  int          n_samp = 0;
  sac_ctrl dut (.*);
  sac_ana_model u_ana (.i_dac_code(o_dac_code), .i_chan_onehot(o_chan_onehot),
    .i_quarter_sel(o_quarter_sel), .i_level(level), .o_comp(i_comp));
  always #20 i_clock = ~i_clock;
  always @(posedge i_clock) begin
    cyc++;
    if (o_bit_step === 1'b1) n_step++;
    if (o_sample === 1'b1) n_samp++;
    if (cyc == 60000) begin
      n_fail++;
      results();
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge i_clock);
    i_psel <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clock);
    i_penable <= 1'b1;
    n = 0;
    do begin
      @(posedge i_clock);
      n++;
    end while (o_pready !== 1'b1 && n < 20);
    rd = o_prdata;
    err = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask
  task t_chan();
    apb(1'b1, 12'h004, 32'h3);
    repeat (2) @(posedge i_clock);
    chk({o_quarter_sel, o_chan_onehot}, 32'h0);
    for (int c = 0; c < 16; c++) begin
      apb(1'b1, 12'h004, 32'h10 | c);
      repeat (2) @(posedge i_clock);
      chk({o_quarter_sel, o_chan_onehot},
          c < 11 ? 32'h1 << c : c == 11 ? 32'h1000 : 32'h0);
    end
  endtask
  task t_pins();
    apb(1'b1, 12'h008, 32'ha5);
    apb(1'b1, 12'h000, 32'h50);
    repeat (2) @(posedge i_clock);
    chk(o_pad_analog, 12'h5a5);
    apb(1'b0, 12'h008, 32'h0);
    chk(rd, 32'ha5);
    chk(err, 1'b0);
    apb(1'b0, 12'h020, 32'h0);
    chk(rd, 32'h0);
    chk(err, 1'b1);
  endtask
  task t_dis();
    n_step = 0;
    apb(1'b1, 12'h000, 32'h2000);
    repeat (20) @(posedge i_clock);
    chk(n_step, 32'h0);
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h0);
  endtask
  task conv(input int dv, input int sh, input int rs, input logic [31:0] ir);
    logic [31:0] cw;
    int n;
    int nb;
    cw = rs | dv << 8 | sh << 10 | ir;
    nb = rs == 0 ? 8 : rs == 1 ? 10 : 12;
    apb(1'b1, 12'h004, 32'h12);
    apb(1'b1, 12'h000, cw);
    apb(1'b1, 12'h000, cw | 32'h1000);
    repeat (6400) @(posedge i_clock);
    n_step = 0;
    n_samp = 0;
    apb(1'b1, 12'h000, cw | 32'h3000);
    apb(1'b0, 12'h00c, 32'h0);
    chk(rd[0], 1'b0);
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, cw | 32'h1000);
    n = 0;
    do begin
      apb(1'b0, 12'h00c, 32'h0);
      n++;
    end while (rd[0] !== 1'b1 && n < 200);
    chk(rd[0], 1'b1);
    chk(n_step, nb);
    chk(n_samp, (1 << sh) * (dv == 0 ? 16 : dv == 1 ? 8 : dv == 2 ? 1 : 2));
    apb(1'b0, 12'h010, 32'h0);
    chk(rd, level & (12'hfff << (12 - nb)));
  endtask
  task t_irq();
    conv(2, 0, 0, 32'h0);
    apb(1'b0, 12'h00c, 32'h0);
    chk(rd[1], 1'b0);
    chk(o_irq, 1'b0);
    apb(1'b1, 12'h000, 32'h4000);
    apb(1'b1, 12'h00c, 32'h2);
    apb(1'b0, 12'h00c, 32'h0);
    chk(rd[1], 1'b1);
    chk(o_irq, 1'b0);
    apb(1'b1, 12'h000, 32'hc000);
    repeat (2) @(posedge i_clock);
    chk(o_irq, 1'b1);
    apb(1'b1, 12'h00c, 32'h0);
    repeat (2) @(posedge i_clock);
    chk(o_irq, 1'b0);
  endtask
  task results();
    $display("checks %0d fails %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge i_clock);
    i_rst <= 1'b0;
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h0);
    t_chan();
    t_pins();
    t_dis();
    conv(0, 3, 2, 32'h0);
    conv(1, 1, 1, 32'h0);
    conv(3, 2, 3, 32'h0);
    t_irq();
    results();
  end
endmodule
bind sac_ctrl sac_ctrl_asserts u_ast (.*);
`default_nettype wire
